// ---- shared/psc_pkg.sv ----
// constants and types shared by the strap configuration latch
package psc_pkg;

   // clock
   localparam int CLK_PERIOD_NS   = 100;

   // reset pin pulse classification, times in ns
   localparam int PARTIAL_MIN_NS  = 100;
   localparam int FULL_MIN_NS     = 1000;
   localparam int SHUTDOWN_MIN_NS = 10000;

   // least times round up to whole cycles
   localparam logic [7:0] PARTIAL_MIN_CYC =
      8'((PARTIAL_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [7:0] FULL_MIN_CYC =
      8'((FULL_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [7:0] SHUTDOWN_MIN_CYC =
      8'((SHUTDOWN_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

   // range strap codes
   localparam logic [1:0] RANGE_SOFTWARE = 2'h0;
   localparam logic [1:0] RANGE_NARROW   = 2'h1;
   localparam logic [1:0] RANGE_MIDDLE   = 2'h2;
   localparam logic [1:0] RANGE_WIDE     = 2'h3;

   // serial frame lengths in bits
   localparam logic [5:0] LANE_BITS_DUAL   = 6'h10;
   localparam logic [5:0] LANE_BITS_SINGLE = 6'h20;

   // register byte offsets
   localparam logic [3:0] REG_STATUS   = 4'h0;
   localparam logic [3:0] REG_SW_RANGE = 4'h4;
   localparam logic [3:0] REG_RST_CNT  = 4'h8;

   // status field positions
   localparam int ST_RANGE_LSB  = 0;
   localparam int ST_CFG_VALID  = 2;
   localparam int ST_SW_MODE    = 3;
   localparam int ST_SERIAL     = 4;
   localparam int ST_DUAL_LANE  = 5;
   localparam int ST_SHUTDOWN   = 6;
   localparam int ST_WARN_LOW   = 7;
   localparam int ST_WARN_SEQ   = 8;
   localparam int ST_BUSY       = 9;

   // reset counter field positions
   localparam int RC_PARTIAL_LSB = 0;
   localparam int RC_FULL_LSB    = 8;

   // values after reset
   localparam logic [1:0] SW_RANGE_RESET = 2'h3;

   // reset pin tracker states
   typedef enum logic [1:0] {
      PSC_RUN,
      PSC_LOW,
      PSC_SHUTDOWN
   } psc_rst_state_type;

endpackage

// ---- design/psc_sync.sv ----
// two-stage synchroniser for a group of pin inputs
module psc_sync #(
   parameter int WIDTH = 1
) (
   // clock and reset
   input  wire logic             clk_sys,
   input  wire logic             rst,
   // pin side
   input  wire logic [WIDTH-1:0] pin_in,
   // synchronised side
   output logic      [WIDTH-1:0] sync_out
);

   logic [WIDTH-1:0] stage1_r;
   logic [WIDTH-1:0] stage2_r;

   // first stage feeds only the second stage
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         stage1_r <= '0;
         stage2_r <= '0;
      end else begin
         stage1_r <= pin_in;
         stage2_r <= stage1_r;
      end
   end

   assign sync_out = stage2_r;

endmodule

// ---- design/psc_strap_latch.sv ----
// strap capture, reset pulse classification and serial lane routing
//
// Chosen here: the register addresses and the strobed register port.

// Notes on behaviour
// - mode choice latched at full reset only
// - hardware mode range follows straps live
// - strap code 00 selects software mode
// - codes 01,10,11 pick narrow, middle, wide
// - interface strap latched: low parallel, high serial
// - one lane: all output on first line
// - two lanes: output split across both lines
// - lane strap sampled at full reset release
// - reset pulse length picks partial, full, shutdown
module psc_strap_latch (
   // clock and reset
   input  wire logic        clk_sys,
   input  wire logic        rst,
   // pins from the board
   input  wire logic        reset_pin_n,
   input  wire logic        range_mode_strap_hi,
   input  wire logic        range_mode_strap_lo,
   input  wire logic        interface_select_strap,
   input  wire logic        serial_lane_count_strap,
   input  wire logic        sequencer_enable_strap,
   input  wire logic [3:0]  parallel_low_bits,
   // conversion results from the core
   input  wire logic        conv_start,
   input  wire logic [15:0] conv_data_a,
   input  wire logic [15:0] conv_data_b,
   // register port
   input  wire logic [3:0]  reg_addr,
   input  wire logic [31:0] reg_wdata,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   output logic      [31:0] reg_rdata,
   // configuration outputs
   output logic             cfg_valid,
   output logic             software_mode,
   output logic [1:0]       input_range,
   output logic             serial_if,
   output logic             dual_lane,
   output logic             shutdown,
   output logic             full_reset_pulse,
   output logic             partial_reset_pulse,
   // serial data outputs
   output logic             serial_out_first,
   output logic             serial_out_second,
   output logic             serial_frame_valid
);

   typedef struct packed {
      psc_pkg::psc_rst_state_type rst_st;
      logic [7:0]  low_cnt;
      logic        cfg_valid;
      logic        sw_mode;
      logic        serial_if;
      logic        dual_lane;
      logic [1:0]  range;
      logic [1:0]  sw_range;
      logic        shutdown;
      logic        full_pulse;
      logic        partial_pulse;
      logic [7:0]  partial_cnt;
      logic [7:0]  full_cnt;
      logic        warn_low;
      logic        warn_seq;
      logic [31:0] rdata;
      logic [31:0] shift_a;
      logic [15:0] shift_b;
      logic [5:0]  bit_cnt;
      logic        busy;
      logic        sdo_a;
      logic        sdo_b;
      logic        sdo_valid;
   } psc_state_type;

   psc_state_type state_r;
   psc_state_type state_nxt;

   logic [9:0] pins_s;
   logic       rst_pin_s;
   logic [1:0] range_s;
   logic       if_s;
   logic       lane_s;
   logic       seq_s;
   logic [3:0] low_bits_s;
   logic       accept;
   logic       released;

   psc_sync #(
      .WIDTH (10)
   ) u_sync (
      .clk_sys  (clk_sys),
      .rst      (rst),
      .pin_in   ({~reset_pin_n, range_mode_strap_hi, range_mode_strap_lo,
                  interface_select_strap, serial_lane_count_strap,
                  sequencer_enable_strap, parallel_low_bits}),
      .sync_out (pins_s)
   );

   // carried inverted: the cleared synchroniser must read as released,
   // else a false partial pulse follows every reset
   assign rst_pin_s  = ~pins_s[9];
   assign range_s    = pins_s[8:7];
   assign if_s       = pins_s[6];
   assign lane_s     = pins_s[5];
   assign seq_s      = pins_s[4];
   assign low_bits_s = pins_s[3:0];

   // pin back high after a low stretch
   assign released = rst_pin_s && (state_r.rst_st != psc_pkg::PSC_RUN);

   // a frame starts only with a settled serial configuration
   assign accept = conv_start && !state_r.busy && state_r.cfg_valid &&
                   state_r.serial_if && (state_r.rst_st == psc_pkg::PSC_RUN);

   always_comb begin
      state_nxt               = state_r;
      state_nxt.full_pulse    = 1'b0;
      state_nxt.partial_pulse = 1'b0;
      state_nxt.rdata         = 32'h0000_0000;

      // reset pin tracker
      case (state_r.rst_st)
         psc_pkg::PSC_RUN: begin
            state_nxt.low_cnt = 8'h00;
            if (!rst_pin_s) begin
               state_nxt.rst_st  = psc_pkg::PSC_LOW;
               state_nxt.low_cnt = 8'h01;
            end
         end
         psc_pkg::PSC_LOW: begin
            if (!rst_pin_s) begin
               state_nxt.low_cnt = state_r.low_cnt + 8'h01;
               // held low long enough: the part powers down
               if (state_r.low_cnt + 8'h01 >= psc_pkg::SHUTDOWN_MIN_CYC) begin
                  state_nxt.rst_st   = psc_pkg::PSC_SHUTDOWN;
                  state_nxt.shutdown = 1'b1;
               end
            end else begin
               state_nxt.rst_st = psc_pkg::PSC_RUN;
            end
         end
         psc_pkg::PSC_SHUTDOWN: begin
            if (rst_pin_s) begin
               state_nxt.rst_st   = psc_pkg::PSC_RUN;
               state_nxt.shutdown = 1'b0;
            end
         end
         default: begin
            state_nxt.rst_st = psc_pkg::PSC_RUN;
         end
      endcase

      // classify the pulse on its release
      if (released) begin
         if (state_r.low_cnt >= psc_pkg::FULL_MIN_CYC) begin
            state_nxt.full_pulse = 1'b1;
            state_nxt.full_cnt   = state_r.full_cnt + 8'h01;
            state_nxt.cfg_valid  = 1'b1;
            // straps loaded only here; partial releases skip this
            state_nxt.sw_mode    =
               (range_s == psc_pkg::RANGE_SOFTWARE);
            state_nxt.serial_if  = if_s;
            state_nxt.dual_lane  = lane_s;
         end else if (state_r.low_cnt >= psc_pkg::PARTIAL_MIN_CYC) begin
            state_nxt.partial_pulse = 1'b1;
            state_nxt.partial_cnt   = state_r.partial_cnt + 8'h01;
         end
      end

      // range: live straps in hardware mode, register in software mode
      if (state_nxt.sw_mode) begin
         state_nxt.range = state_r.sw_range;
      end else begin
         state_nxt.range = range_s;
      end

      // board misuse, reported as live levels only
      state_nxt.warn_low = state_r.cfg_valid && state_r.serial_if &&
                           (low_bits_s != 4'h0);
      state_nxt.warn_seq = state_r.cfg_valid && state_r.sw_mode &&
                           seq_s;

      // register port
      if (reg_wr && reg_addr == psc_pkg::REG_SW_RANGE) begin
         state_nxt.sw_range = reg_wdata[1:0];
      end
      if (reg_rd) begin
         case (reg_addr)
            psc_pkg::REG_STATUS: begin
               state_nxt.rdata[psc_pkg::ST_RANGE_LSB +: 2] = state_r.range;
               state_nxt.rdata[psc_pkg::ST_CFG_VALID] = state_r.cfg_valid;
               state_nxt.rdata[psc_pkg::ST_SW_MODE]   = state_r.sw_mode;
               state_nxt.rdata[psc_pkg::ST_SERIAL]    = state_r.serial_if;
               state_nxt.rdata[psc_pkg::ST_DUAL_LANE] = state_r.dual_lane;
               state_nxt.rdata[psc_pkg::ST_SHUTDOWN]  = state_r.shutdown;
               state_nxt.rdata[psc_pkg::ST_WARN_LOW]  = state_r.warn_low;
               state_nxt.rdata[psc_pkg::ST_WARN_SEQ]  = state_r.warn_seq;
               state_nxt.rdata[psc_pkg::ST_BUSY]      = state_r.busy;
            end
            psc_pkg::REG_SW_RANGE: begin
               state_nxt.rdata[1:0] = state_r.sw_range;
            end
            psc_pkg::REG_RST_CNT: begin
               state_nxt.rdata[psc_pkg::RC_PARTIAL_LSB +: 8] =
                  state_r.partial_cnt;
               state_nxt.rdata[psc_pkg::RC_FULL_LSB +: 8] = state_r.full_cnt;
            end
            default: begin
               state_nxt.rdata = 32'h0000_0000;
            end
         endcase
      end

      // serial engine
      state_nxt.sdo_valid = state_r.busy;
      state_nxt.sdo_a     = 1'b0;
      state_nxt.sdo_b     = 1'b0;
      if (state_r.busy) begin
         state_nxt.sdo_a   = state_r.shift_a[31];
         state_nxt.shift_a = {state_r.shift_a[30:0], 1'b0};
         if (state_r.dual_lane) begin
            state_nxt.sdo_b   = state_r.shift_b[15];
            state_nxt.shift_b = {state_r.shift_b[14:0], 1'b0};
         end
         state_nxt.bit_cnt = state_r.bit_cnt - 6'h01;
         if (state_r.bit_cnt == 6'h01) begin
            state_nxt.busy = 1'b0;
         end
      end else if (accept) begin
         state_nxt.busy = 1'b1;
         if (state_r.dual_lane) begin
            state_nxt.shift_a = {conv_data_a, 16'h0000};
            state_nxt.shift_b = conv_data_b;
            state_nxt.bit_cnt = psc_pkg::LANE_BITS_DUAL;
         end else begin
            // both words back to back on the first line
            state_nxt.shift_a = {conv_data_a, conv_data_b};
            state_nxt.shift_b = 16'h0000;
            state_nxt.bit_cnt = psc_pkg::LANE_BITS_SINGLE;
         end
      end
      // any low on the reset pin abandons a frame in flight
      if (!rst_pin_s) begin
         state_nxt.busy    = 1'b0;
         state_nxt.bit_cnt = 6'h00;
      end
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         state_r          <= '0;
         state_r.rst_st   <= psc_pkg::PSC_RUN;
         state_r.sw_range <= psc_pkg::SW_RANGE_RESET;
      end else begin
         state_r <= state_nxt;
      end
   end

   assign reg_rdata           = state_r.rdata;
   assign cfg_valid           = state_r.cfg_valid;
   assign software_mode       = state_r.sw_mode;
   assign input_range         = state_r.range;
   assign serial_if           = state_r.serial_if;
   assign dual_lane           = state_r.dual_lane;
   assign shutdown            = state_r.shutdown;
   assign full_reset_pulse    = state_r.full_pulse;
   assign partial_reset_pulse = state_r.partial_pulse;
   assign serial_out_first    = state_r.sdo_a;
   assign serial_out_second   = state_r.sdo_b;
   assign serial_frame_valid  = state_r.sdo_valid;

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);

   sequence s_dual_frame;
      state_r.busy [*8] ##1 state_r.busy [*8] ##1 !state_r.busy;
   endsequence

   sequence s_single_frame;
      state_r.busy [*8] ##1 state_r.busy [*8] ##1 state_r.busy [*8]
      ##1 state_r.busy [*8] ##1 !state_r.busy;
   endsequence

   chk_mode_only_full: assert property (
      !$stable(state_r.sw_mode) |-> state_r.full_pulse)
      else $error("mode changed outside a full reset release");

   chk_range_live: assert property (
      (state_r.cfg_valid && !state_r.sw_mode) |->
      state_r.range == $past(range_s))
      else $error("hardware range does not follow the straps");

   chk_sw_code: assert property (
      state_r.full_pulse |-> state_r.sw_mode == ($past(range_s) == 2'h0))
      else $error("software mode not decoded from code 00");

   chk_hw_range_code: assert property (
      (state_r.cfg_valid && !state_r.sw_mode && $past(range_s) == 2'h1)
      |-> state_r.range == psc_pkg::RANGE_NARROW)
      else $error("code 01 did not give the narrow range");

   chk_if_latched: assert property (
      state_r.full_pulse |-> state_r.serial_if == $past(if_s) ##1
      $stable(state_r.serial_if) || state_r.full_pulse)
      else $error("interface choice not latched at release");

   chk_single_lane: assert property (
      (accept && !state_r.dual_lane) |=> s_single_frame)
      else $error("single lane frame is not 32 bits");

   chk_second_quiet: assert property (
      !state_r.dual_lane |-> !state_r.sdo_b)
      else $error("second line active in one lane mode");

   chk_dual_lane: assert property (
      (accept && state_r.dual_lane) |=> s_dual_frame)
      else $error("dual lane frame is not 16 bits");

   chk_lane_latched: assert property (
      !$stable(state_r.dual_lane) |-> state_r.full_pulse)
      else $error("lane count changed outside a full reset");

   chk_pulse_kind: assert property (
      state_r.partial_pulse |-> $past(state_r.low_cnt) < psc_pkg::FULL_MIN_CYC
      && !state_r.full_pulse)
      else $error("partial reset from a long pulse");

   chk_partial_keeps: assert property (
      state_r.partial_pulse |-> $stable(state_r.sw_mode) &&
      $stable(state_r.serial_if) && $stable(state_r.dual_lane))
      else $error("partial reset disturbed latched straps");

endmodule

// ---- testbench/psc_board_model.sv ----
// board side model driving the configuration straps and the reset pin
module psc_board_model (
   // clock
   input  wire logic       clk_sys,
   // pins to the device
   output logic            reset_pin_n,
   output logic            range_mode_strap_hi,
   output logic            range_mode_strap_lo,
   output logic            interface_select_strap,
   output logic            serial_lane_count_strap,
   output logic            sequencer_enable_strap,
   output logic [3:0]      parallel_low_bits
);
   timeunit 1ns;
   timeprecision 1ns;

   initial begin
      reset_pin_n             = 1'b1;
      range_mode_strap_hi     = 1'b0;
      range_mode_strap_lo     = 1'b0;
      interface_select_strap  = 1'b0;
      serial_lane_count_strap = 1'b0;
   end

   // the low data pins are grounded by the board in serial mode
   assign parallel_low_bits = interface_select_strap ? 4'h0 : 4'hA;
   // sequencer strap grounded whenever the code asks for software mode
   assign sequencer_enable_strap =
      range_mode_strap_hi | range_mode_strap_lo;

   task automatic set_straps(input logic [1:0] code, input logic ser,
                             input logic lanes);
      @(posedge clk_sys);
      {range_mode_strap_hi, range_mode_strap_lo} <= code;
      interface_select_strap  <= ser;
      serial_lane_count_strap <= lanes;
   endtask

   task automatic pin_level(input logic v);
      @(posedge clk_sys);
      reset_pin_n <= v;
   endtask
endmodule

// ---- testbench/psc_strap_latch_tb.sv ----
// self-checking bench for the strap configuration latch
module psc_strap_latch_tb;
   timeunit 1ns;
   timeprecision 1ns;

   logic        clk_sys = 1'b0;
   logic        rst = 1'b1;
   logic        conv_start = 1'b0;
   logic [15:0] conv_data_a = 16'h0000;
   logic [15:0] conv_data_b = 16'h0000;
   logic [3:0]  reg_addr = 4'h0;
   logic [31:0] reg_wdata = 32'h0;
   logic        reg_wr = 1'b0;
   logic        reg_rd = 1'b0;
   logic        reset_pin_n, strap_hi, strap_lo, if_strap, lane_strap;
   logic        seq_strap;
   logic [3:0]  low_bits;
   logic [31:0] reg_rdata;
   logic        cfg_valid, software_mode, serial_if, dual_lane, shutdown;
   logic [1:0]  input_range;
   logic        full_reset_pulse, partial_reset_pulse;
   logic        serial_out_first, serial_out_second, serial_frame_valid;
   logic        f, p;
   logic [31:0] d;
   int          bad_count = 0;
   int          checked = 0;

   always #50 clk_sys = ~clk_sys;

   psc_board_model u_psc_board_model (
      .clk_sys(clk_sys), .reset_pin_n(reset_pin_n),
      .range_mode_strap_hi(strap_hi), .range_mode_strap_lo(strap_lo),
      .interface_select_strap(if_strap),
      .serial_lane_count_strap(lane_strap),
      .sequencer_enable_strap(seq_strap), .parallel_low_bits(low_bits));

   psc_strap_latch u_psc_strap_latch (
      .clk_sys(clk_sys), .rst(rst), .reset_pin_n(reset_pin_n),
      .range_mode_strap_hi(strap_hi), .range_mode_strap_lo(strap_lo),
      .interface_select_strap(if_strap),
      .serial_lane_count_strap(lane_strap),
      .sequencer_enable_strap(seq_strap), .parallel_low_bits(low_bits),
      .conv_start(conv_start), .conv_data_a(conv_data_a),
      .conv_data_b(conv_data_b), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .cfg_valid(cfg_valid),
      .software_mode(software_mode), .input_range(input_range),
      .serial_if(serial_if), .dual_lane(dual_lane), .shutdown(shutdown),
      .full_reset_pulse(full_reset_pulse),
      .partial_reset_pulse(partial_reset_pulse),
      .serial_out_first(serial_out_first),
      .serial_out_second(serial_out_second),
      .serial_frame_valid(serial_frame_valid));

   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", checked, bad_count);
      if (bad_count == 0 && checked > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   task automatic check(input string name, input logic [31:0] seen,
                        input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         bad_count++;
         $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic reg_write(input logic [3:0] a, input logic [31:0] v);
      @(posedge clk_sys);
      reg_wr    <= 1'b1;
      reg_addr  <= a;
      reg_wdata <= v;
      @(posedge clk_sys);
      reg_wr <= 1'b0;
   endtask

   task automatic reg_read(input logic [3:0] a, output logic [31:0] v);
      @(posedge clk_sys);
      reg_rd   <= 1'b1;
      reg_addr <= a;
      @(posedge clk_sys);
      reg_rd <= 1'b0;
      #1 v = reg_rdata;
   endtask

   // low pulse on the reset pin, then note which pulse kind was reported
   task automatic pulse(input int n, output logic full, output logic part);
      u_psc_board_model.pin_level(1'b0);
      repeat (n) @(posedge clk_sys);
      u_psc_board_model.pin_level(1'b1);
      full = 1'b0;
      part = 1'b0;
      repeat (8) begin
         @(negedge clk_sys);
         full = full | full_reset_pulse;
         part = part | partial_reset_pulse;
      end
   endtask

   task automatic frame(input logic [15:0] a, input logic [15:0] b,
                        input int n, input logic [31:0] e1,
                        input logic [31:0] e2);
      logic [31:0] s1;
      logic [31:0] s2;
      int          k;
      s1 = 32'h0;
      s2 = 32'h0;
      k = 0;
      @(posedge clk_sys);
      conv_start  <= 1'b1;
      conv_data_a <= a;
      conv_data_b <= b;
      @(posedge clk_sys);
      conv_start <= 1'b0;
      @(negedge clk_sys);
      while (serial_frame_valid !== 1'b1 && k < 10) begin
         @(negedge clk_sys);
         k++;
      end
      if (k == 10) begin
         bad_count++;
         tally_and_finish();
      end
      for (int i = 0; i < n; i++) begin
         s1 = {s1[30:0], serial_out_first};
         s2 = {s2[30:0], serial_out_second};
         @(negedge clk_sys);
      end
      check("lane one", s1, e1);
      check("lane two", s2, e2);
      check("frame end", {31'h0, serial_frame_valid}, 32'h0);
   endtask

   initial begin
      repeat (16) @(posedge clk_sys);
      rst <= 1'b0;
      @(negedge clk_sys);
      check("cfg before full", {31'h0, cfg_valid}, 32'h0);
      u_psc_board_model.set_straps(2'h1, 1'b1, 1'b1);
      pulse(15, f, p);
      check("full pulse", {30'h0, f, p}, 32'h2);
      check("cfg", {29'h0, cfg_valid, software_mode, serial_if},
            32'h5);
      check("range", {30'h0, input_range}, 32'h1);
      check("dual", {31'h0, dual_lane}, 32'h1);
      // straps moved without a reset: only the range follows
      u_psc_board_model.set_straps(2'h2, 1'b0, 1'b0);
      repeat (6) @(negedge clk_sys);
      check("live range", {30'h0, input_range}, 32'h2);
      check("iface held", {31'h0, serial_if}, 32'h1);
      check("lanes held", {31'h0, dual_lane}, 32'h1);
      // board now drives the low bits while serial is still latched
      reg_read(psc_pkg::REG_STATUS, d);
      check("warn low", d, 32'h0000_00B6);
      u_psc_board_model.set_straps(2'h3, 1'b0, 1'b0);
      repeat (6) @(negedge clk_sys);
      check("wide range", {30'h0, input_range}, 32'h3);
      u_psc_board_model.set_straps(2'h0, 1'b0, 1'b0);
      pulse(4, f, p);
      check("part pulse", {30'h0, f, p}, 32'h1);
      check("mode kept", {31'h0, software_mode}, 32'h0);
      check("latch kept", {30'h0, serial_if, dual_lane}, 32'h3);
      frame(16'hA5C3, 16'h3C5A, 16, 32'hA5C3, 32'h3C5A);
      // software mode, one lane
      u_psc_board_model.set_straps(2'h0, 1'b1, 1'b0);
      pulse(15, f, p);
      check("sw mode", {31'h0, software_mode}, 32'h1);
      check("sw range rst", {30'h0, input_range}, 32'h3);
      check("one lane", {31'h0, dual_lane}, 32'h0);
      reg_write(psc_pkg::REG_SW_RANGE, 32'h1);
      reg_read(psc_pkg::REG_SW_RANGE, d);
      check("sw range reg", d, 32'h1);
      check("sw range", {30'h0, input_range}, 32'h1);
      frame(16'h8421, 16'h1248, 32, 32'h84211248, 32'h0);
      // pin held low long enough to shut down
      u_psc_board_model.set_straps(2'h1, 1'b0, 1'b0);
      u_psc_board_model.pin_level(1'b0);
      repeat (110) @(posedge clk_sys);
      #1 check("shutdown", {31'h0, shutdown}, 32'h1);
      pulse(0, f, p);
      check("shut release", {30'h0, f, shutdown}, 32'h2);
      check("parallel", {31'h0, serial_if}, 32'h0);
      reg_write(psc_pkg::REG_STATUS, 32'hFFFF);
      reg_read(psc_pkg::REG_STATUS, d);
      check("status", d, 32'h5);
      reg_read(4'hC, d);
      check("unmapped", d, 32'h0);
      // three full releases and one partial since reset, none spurious
      reg_read(psc_pkg::REG_RST_CNT, d);
      check("reset counts", d, 32'h0000_0301);
      tally_and_finish();
   end
endmodule
